// ===== hdl/audio_serial_consts.vh
// Purpose : Constants for the audio serial configuration and codec block.
// Assumes : Included by bare name from the design files.
// Notes   : Definitions only, guarded against double inclusion.
`ifndef AUDIO_SERIAL_CONSTS_VH
`define AUDIO_SERIAL_CONSTS_VH

// ----------------------------------------------------------------------
// Register addresses on the 16-bit data space.
// ----------------------------------------------------------------------
`define ADDR_CONFIG_0      16'hDF40
`define ADDR_SAMPLE_LOW    16'hDF42
`define ADDR_SAMPLE_HIGH   16'hDF43

// ----------------------------------------------------------------------
// Field positions in audio_serial_config_0.
// ----------------------------------------------------------------------
`define BIT_TX_IRQ_ENABLE  7
`define BIT_RX_IRQ_ENABLE  6
`define BIT_EXPAND_ENABLE  5
`define BIT_COMPRESS_ENABLE 4
`define BIT_TX_MONO        3
`define BIT_RX_MONO        2
`define BIT_MASTER         1
`define BIT_ENABLE         0

// ----------------------------------------------------------------------
// Reset values and timing.
// ----------------------------------------------------------------------
`define CONFIG_0_RESET     8'h00
`define SAMPLE_RESET       16'h0000
`define CLK_PERIOD_NS      40
`define SCK_HALF_NS        160
`define WORD_BITS          16

// ----------------------------------------------------------------------
// Companding constants.
// ----------------------------------------------------------------------
`define MULAW_BIAS         16'h0084
`define MULAW_CLIP         16'h7F7B

`endif

// ===== hdl/mulaw_codec.v
// Purpose : Combinational mu-law compressor and expander.
// Assumes : 16-bit two's complement linear samples.
// Notes   : Both directions are pure logic; the caller registers results.
`timescale 1ns/100ps
`include "audio_serial_consts.vh"

module mulaw_codec (
    // Linear to compressed.
    input  wire [15:0] linear_in,
    output wire [7:0]  code_out,
    // Compressed to linear.
    input  wire [7:0]  code_in,
    output wire [15:0] linear_out
);

    // Compress one sample: biased magnitude, segment search, mantissa.
    function [7:0] compress;
        input [15:0] x;
        reg   [15:0] mag;
        reg   [2:0]  seg;
        reg   [15:0] sh;
        integer      i;
        begin
            mag = x[15] ? (~x + 16'h0001) : x;
            if (mag > `MULAW_CLIP) begin
                mag = `MULAW_CLIP;
            end
            mag = mag + `MULAW_BIAS;
            seg = 3'd0;
            for (i = 0; i < 8; i = i + 1) begin
                if (mag[i + 7]) begin
                    seg = i[2:0];
                end
            end
            // Four bits for the shift: segments five and up need 8 to 10.
            sh = mag >> ({1'b0, seg} + 4'd3);
            compress = ~{x[15], seg, sh[3:0]};
        end
    endfunction

    // Expand one code back to a 16-bit linear sample.
    function [15:0] expand;
        input [7:0] c;
        reg   [7:0]  n;
        reg   [15:0] t;
        begin
            n = ~c;
            t = ({8'h00, 1'b0, n[3:0], 3'b000} + `MULAW_BIAS) << n[6:4];
            expand = n[7] ? (`MULAW_BIAS - t) : (t - `MULAW_BIAS);
        end
    endfunction

    // Both directions are evaluated every cycle.
    assign code_out   = compress(linear_in);
    assign linear_out = expand(code_in);

endmodule // mulaw_codec

// ===== hdl/audio_serial_config.v
// Purpose : Audio serial port with its first configuration register,
//           the sample data registers and a mu-law codec.
// Assumes : 8-bit register port; bit clock and word select sampled on
//           sys_clk when slave; 16-bit words when master.
// Notes   : When disabled the codec serves software directly.
// Contract
// - Disabled with expansion on, a write of the high byte expands it.
// - Enabled with expansion on, each transmit byte is expanded first.
// - Disabled with compression on and expansion off, the 16-bit sample is compressed.
// - Enabled with compression on, received samples are compressed.
// - Transmit mono sends each sample in both channels, else stereo.
// - Receive mono drops right-channel words, else stereo.
// - Role bit clear makes the port slave, taking clock and select in.
// - Role bit set makes the port drive clock and select itself.
// - Enable starts serial work; clear stops it, codec stays usable.
// - A standalone conversion is readable the cycle after the write.
`timescale 1ns/100ps
`include "audio_serial_consts.vh"

module audio_serial_config (
    // Clock and reset.
    input  wire        sys_clk,
    input  wire        rst,
    // Register port.
    input  wire [15:0] reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    // Serial pins.
    input  wire        sck_in,
    output reg         sck_out,
    output wire        sck_oe,
    input  wire        ws_in,
    output reg         ws_out,
    output wire        ws_oe,
    input  wire        sd_in,
    output reg         sd_out,
    // Interrupt requests toward the processor.
    output wire        tx_irq,
    output wire        rx_irq
);

    localparam HALF_CYCLES = `SCK_HALF_NS / `CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Configuration and data registers
    // ------------------------------------------------------------------
    reg  [7:0]  audio_serial_config_0;
    reg  [15:0] sample;
    reg  [15:0] tx_hold;
    reg         tx_full;
    reg         rx_full;
    reg         low_written;
    reg  [15:0] tx_shift;
    reg  [15:0] rx_shift;
    reg  [4:0]  rx_count;
    reg         tx_ws;
    reg         rx_ws;
    reg  [7:0]  div_count;
    reg  [3:0]  bit_count;
    reg         sck_m;
    reg         sck_s;
    reg         sck_p;
    reg         ws_m;
    reg         ws_s;
    reg         sd_m;
    reg         sd_s;

    wire enab     = audio_serial_config_0[`BIT_ENABLE];
    wire master   = audio_serial_config_0[`BIT_MASTER];
    wire expand   = audio_serial_config_0[`BIT_EXPAND_ENABLE];
    wire compress = audio_serial_config_0[`BIT_COMPRESS_ENABLE];
    wire tx_mono  = audio_serial_config_0[`BIT_TX_MONO];
    wire rx_mono  = audio_serial_config_0[`BIT_RX_MONO];

    wire wr_cfg  = reg_wr && (reg_addr == `ADDR_CONFIG_0);
    wire wr_low  = reg_wr && (reg_addr == `ADDR_SAMPLE_LOW);
    wire wr_high = reg_wr && (reg_addr == `ADDR_SAMPLE_HIGH);
    wire rd_high = reg_rd && (reg_addr == `ADDR_SAMPLE_HIGH);

    // ------------------------------------------------------------------
    // Bit clock events
    // ------------------------------------------------------------------
    // The third stage only feeds edge detection, never the first flop.
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sck_m <= 1'b0;
            sck_s <= 1'b0;
            sck_p <= 1'b0;
            ws_m  <= 1'b0;
            ws_s  <= 1'b0;
            sd_m  <= 1'b0;
            sd_s  <= 1'b0;
        end else begin
            sck_m <= sck_in;
            sck_s <= sck_m;
            sck_p <= sck_s;
            ws_m  <= ws_in;
            ws_s  <= ws_m;
            sd_m  <= sd_in;
            sd_s  <= sd_m;
        end
    end

    wire div_tick   = (div_count == HALF_CYCLES - 1);
    wire m_rise     = master && div_tick && !sck_out;
    wire m_fall     = master && div_tick && sck_out;
    wire next_ws    = (bit_count == `WORD_BITS - 1) ? ~ws_out : ws_out;
    wire s_rise     = !master && sck_s && !sck_p;
    wire s_fall     = !master && !sck_s && sck_p;
    wire rise       = enab && (m_rise || s_rise);
    wire fall       = enab && (m_fall || s_fall);
    wire ws_at_fall = master ? next_ws : ws_s;
    wire ws_at_rise = master ? ws_out : ws_s;

    // master generator
    // Clock and select are driven only while enabled as master.
    assign sck_oe = enab && master;
    assign ws_oe  = enab && master;

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            div_count <= 8'h00;
            bit_count <= 4'h0;
            sck_out   <= 1'b0;
            ws_out    <= 1'b0;
        end else if (!(enab && master)) begin
            div_count <= 8'h00;
            bit_count <= 4'h0;
            sck_out   <= 1'b0;
            ws_out    <= 1'b0;
        end else begin
            div_count <= div_tick ? 8'h00 : div_count + 8'h01;
            if (div_tick) begin
                sck_out <= ~sck_out;
            end
            // Select changes on a falling edge once per word.
            if (m_fall) begin
                bit_count <= bit_count + 4'h1;
                ws_out    <= next_ws;
            end
        end
    end

    // ------------------------------------------------------------------
    // Codec
    // ------------------------------------------------------------------
    wire [15:0] comp_in = enab ? rx_shift : {reg_wdata, sample[7:0]};
    wire [7:0]  exp_in  = enab ? tx_hold[15:8] : reg_wdata;
    wire [7:0]  comp_out;
    wire [15:0] exp_out;

    mulaw_codec u_codec (
        .linear_in  (comp_in),
        .code_out   (comp_out),
        .code_in    (exp_in),
        .linear_out (exp_out)
    );

    wire [15:0] tx_word = expand ? exp_out : tx_hold;

    // ------------------------------------------------------------------
    // Transmit path
    // ------------------------------------------------------------------
    // A word boundary on the falling edge loads the next word; the MSB
    // then leaves one bit clock later as the serial format expects.
    wire tx_start = fall && (ws_at_fall != tx_ws);
    wire tx_take  = tx_start && tx_full && !(tx_mono && !ws_at_fall);

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tx_shift     <= `SAMPLE_RESET;
            tx_ws        <= 1'b0;
            sd_out       <= 1'b0;
        end else if (!enab) begin
            tx_shift     <= `SAMPLE_RESET;
            tx_ws        <= 1'b0;
            sd_out       <= 1'b0;
        end else if (fall) begin
            sd_out <= tx_shift[15];
            tx_ws  <= ws_at_fall;
            if (tx_start) begin
                // An empty buffer sends zeros rather than stale data.
                tx_shift     <= tx_full ? tx_word : `SAMPLE_RESET;
            end else begin
                tx_shift <= {tx_shift[14:0], 1'b0};
            end
        end
    end

    // ------------------------------------------------------------------
    // Receive path
    // ------------------------------------------------------------------
    // The first rising edge after a select change carries the last bit
    // of the previous channel; bits beyond sixteen are discarded.
    wire rx_end   = rise && (ws_at_rise != rx_ws);
    wire rx_store = rx_end && !(rx_mono && rx_ws);
    wire [15:0] rx_last = (rx_count < 5'd16) ?
                          {rx_shift[14:0], sd_s} : rx_shift;

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rx_shift <= `SAMPLE_RESET;
            rx_count <= 5'd0;
            rx_ws    <= 1'b0;
        end else if (!enab) begin
            rx_shift <= `SAMPLE_RESET;
            rx_count <= 5'd0;
            rx_ws    <= 1'b0;
        end else if (rise) begin
            rx_ws <= ws_at_rise;
            if (rx_end) begin
                rx_count <= 5'd0;
                rx_shift <= `SAMPLE_RESET;
            end else if (rx_count < 5'd16) begin
                rx_shift <= {rx_shift[14:0], sd_s};
                rx_count <= rx_count + 5'd1;
            end else begin
                rx_shift <= rx_shift;
                rx_count <= rx_count;
            end
        end
    end

    // Compression of a received word needs the final bit folded in.
    wire [7:0] rx_code;
    mulaw_codec u_rx_codec (
        .linear_in  (rx_last),
        .code_out   (rx_code),
        .code_in    (8'h00),
        .linear_out ()
    );

    // ------------------------------------------------------------------
    // Register writes, data register and flags
    // ------------------------------------------------------------------
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            audio_serial_config_0 <= `CONFIG_0_RESET;
            sample      <= `SAMPLE_RESET;
            tx_hold     <= `SAMPLE_RESET;
            tx_full     <= 1'b0;
            rx_full     <= 1'b0;
            low_written <= 1'b0;
        end else begin
            if (wr_cfg) begin
                audio_serial_config_0 <= reg_wdata;
            end
            if (wr_low) begin
                sample[7:0] <= reg_wdata;
                low_written <= 1'b1;
            end
            // one codec enable
            // With both enables set, expansion takes priority.
            if (wr_high && !enab) begin
                if (expand) begin
                    sample <= exp_out;
                end else if (compress) begin
                    sample[15:8] <= comp_out;
                end else begin
                    sample[15:8] <= reg_wdata;
                end
                low_written <= 1'b0;
            end
            // A high write fills the transmit buffer; a stale low byte
            // is cleared so it never repeats into the next sample.
            if (wr_high && enab) begin
                sample[15:8] <= reg_wdata;
                tx_hold      <= {reg_wdata,
                                 (low_written || wr_low) ? sample[7:0] :
                                 8'h00};
                low_written  <= 1'b0;
            end
            // Buffer full flag: a new write wins over a take.
            if (wr_high && enab) begin
                tx_full <= 1'b1;
            end else if (tx_take || !enab) begin
                tx_full <= 1'b0;
            end
            if (rx_store) begin
                if (compress) begin
                    sample[15:8] <= rx_code;
                end else begin
                    sample <= rx_last;
                end
            end
            // Ready flag: an arriving word wins over the reading access.
            if (rx_store) begin
                rx_full <= 1'b1;
            end else if (rd_high || !enab) begin
                rx_full <= 1'b0;
            end
        end
    end

    assign tx_irq = audio_serial_config_0[`BIT_TX_IRQ_ENABLE] &&
                    enab && !tx_full;
    assign rx_irq = audio_serial_config_0[`BIT_RX_IRQ_ENABLE] && rx_full;

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Unmapped addresses read as zero.
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `ADDR_CONFIG_0:    reg_rdata <= audio_serial_config_0;
                `ADDR_SAMPLE_LOW:  reg_rdata <= sample[7:0];
                `ADDR_SAMPLE_HIGH: reg_rdata <= sample[15:8];
                default:           reg_rdata <= 8'h00;
            endcase
        end
    end

endmodule // audio_serial_config

// ===== testbench/audio_serial_config_sva.sv
// Purpose : Assertions for the audio serial config block.
// Assumes : Sees only the top module ports.
// Notes   : Shadows the config register from observed writes.
`timescale 1ns/100ps
`include "audio_serial_consts.vh"

module audio_serial_config_sva (
    // Clock, reset and register port.
    input wire        sys_clk,
    input wire        rst,
    input wire [15:0] reg_addr,
    input wire [7:0]  reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [7:0]  reg_rdata,
    // Serial pins and requests.
    input wire        sck_in,
    input wire        sck_out,
    input wire        sck_oe,
    input wire        ws_in,
    input wire        ws_out,
    input wire        ws_oe,
    input wire        sd_in,
    input wire        sd_out,
    input wire        tx_irq,
    input wire        rx_irq
);
    logic [7:0] cfg;
    wire        wr_hi = reg_wr && reg_addr == `ADDR_SAMPLE_HIGH;

    // Config shadow, so the gating checks need no design internals.
    always @(posedge sys_clk or posedge rst) begin
        if (rst)
            cfg <= `CONFIG_0_RESET;
        else if (reg_wr && reg_addr == `ADDR_CONFIG_0)
            cfg <= reg_wdata;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // ----------------------------------------------------------------
    // Pins, requests and register reads
    // ----------------------------------------------------------------
    pin_drive_a: assert property (
        ws_oe == sck_oe && sck_oe == (cfg[1] && cfg[0]))
        else $error("pin drive does not follow role");
    clock_idle_a: assert property (!sck_oe [*2] |-> !sck_out)
        else $error("bit clock moves while not driven");
    clock_half_a: assert property (
        $rose(sck_out) |=> (sck_out || !sck_oe) [*3] ##1 !sck_out)
        else $error("bit clock high half not four cycles");
    tx_gate_a: assert property (tx_irq |-> cfg[7] && cfg[0])
        else $error("transmit request while masked");
    rx_gate_a: assert property (rx_irq |-> cfg[6])
        else $error("receive request while masked");
    rx_off_a: assert property (!cfg[0] [*2] |-> !rx_irq)
        else $error("receive request while off");
    tx_full_a: assert property (wr_hi && cfg[0] |=> !tx_irq)
        else $error("transmit request after a sample write");
    cfg_read_a: assert property (
        reg_rd && reg_addr == `ADDR_CONFIG_0 |=> reg_rdata == $past(cfg))
        else $error("config read back differs");
    unmapped_a: assert property (
        reg_rd && reg_addr[15:4] != 12'hDF4 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");

    cover property (wr_hi && cfg[5] && !cfg[0]);
    cover property ($rose(rx_irq));
    cover property ($rose(sck_out) && sck_oe);
endmodule // audio_serial_config_sva

bind audio_serial_config audio_serial_config_sva chk (
    .sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .sck_in, .sck_out, .sck_oe, .ws_in, .ws_out, .ws_oe, .sd_in, .sd_out,
    .tx_irq, .rx_irq);

// ===== testbench/i2s_codec_model.sv
// Purpose : Behavioural audio codec on the far side of the link.
// Assumes : Sixteen-bit words, left channel while word select is low.
// Notes   : Bit clock phase is offset from the system clock.
`timescale 1ns/100ps

module i2s_codec_model (
    // Bench control and words to send.
    input  wire        gen,
    input  wire [15:0] left_w,
    input  wire [15:0] right_w,
    // Resolved pad lines.
    input  wire        sck_line,
    input  wire        ws_line,
    input  wire        sd_line,
    // Lines driven while this model is the clock master.
    output logic       sck_gen,
    output logic       ws_gen,
    output logic       sd_gen
);
    wire [31:0]  frm = {left_w, right_w};
    logic [4:0]  cnt = 5'h00;
    logic [15:0] sh = 16'h0000;
    logic        wl = 1'b0;
    logic [16:0] seen [$];

    // clock and select
    // The clock stands low between runs, while the data line keeps
    // toggling so that a stale bit is never taken for a real one.
    initial begin
        sck_gen = 1'b0;
        ws_gen = 1'b0;
        sd_gen = 1'b0;
        #7;
        forever begin
            #160;
            if (gen) begin
                sck_gen = ~sck_gen;
                if (!sck_gen) begin
                    cnt = cnt + 5'h01;
                    ws_gen = cnt[4];
                    sd_gen = frm[~(cnt - 5'h01)];
                end
            end else begin
                sck_gen = 1'b0;
                sd_gen = ~sd_gen;
            end
        end
    end

    // word capture
    // A word closes at the first rising edge after word select moves.
    always @(posedge sck_line) begin
        sh = {sh[14:0], sd_line};
        if (ws_line !== wl)
            seen.push_back({wl, sh});
        wl = ws_line;
    end
endmodule // i2s_codec_model

// ===== testbench/tb_audio_serial_config.sv
// Purpose : Self-checking bench for the audio serial config block.
// Assumes : Registers reached by one-cycle strobes on sys_clk.
// Notes   : Table rows cover the standalone codec; link cases follow.
`timescale 1ns/100ps
`include "audio_serial_consts.vh"

module tb_audio_serial_config;
    logic        sys_clk = 1'b0;
    logic        rst;
    logic [15:0] reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    wire  [7:0]  reg_rdata;
    wire         sck_out, sck_oe, ws_out, ws_oe, sd_out, tx_irq, rx_irq;
    wire         m_sck, m_ws, m_sd;
    wire         sck_line = sck_oe ? sck_out : m_sck;
    wire         ws_line = ws_oe ? ws_out : m_ws;
    logic        gen;
    logic [15:0] left_w, right_w, w, prev;
    logic [7:0]  rv, rl;
    int          fail_count = 0;
    int          check_count = 0;
    // Config, low, high, expected high, expected low, low checked.
    logic [47:0] rows [12] = '{
        48'h00_5A_A5_A5_5A_01, 48'hCE_11_22_22_11_01,
        48'h20_00_FF_00_00_01, 48'h20_00_00_82_84_01,
        48'h20_00_80_7D_7C_01, 48'h20_00_E5_01_24_01,
        48'h10_7C_7D_80_00_00, 48'h10_84_82_00_00_00,
        48'h10_78_00_F0_00_00, 48'h10_FF_7F_80_00_00,
        48'h10_00_00_FF_00_00, 48'h30_00_F0_00_78_01};
    logic [15:0] rst_addr [4] = '{`ADDR_CONFIG_0, `ADDR_SAMPLE_LOW,
        `ADDR_SAMPLE_HIGH, 16'hDE40};

    audio_serial_config dut (
        .sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .sck_in(sck_line), .sck_out, .sck_oe,
        .ws_in(ws_line), .ws_out, .ws_oe, .sd_in(m_sd), .sd_out,
        .tx_irq, .rx_irq);
    i2s_codec_model codec (
        .gen, .left_w, .right_w, .sck_line, .ws_line, .sd_line(sd_out),
        .sck_gen(m_sck), .ws_gen(m_ws), .sd_gen(m_sd));

    // System clock, 40 ns period.
    always #20 sys_clk = ~sys_clk;

    // Compare and count; unknowns never match.
    task automatic check(input logic [15:0] got, exp, input string s);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, s, got, exp);
        end
    endtask

    // One-cycle write strobe, taken at the next edge; an idle edge
    // follows so back-to-back writes never drive the strobe twice.
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask

    // Read strobe; the data is settled one edge after it is taken.
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        d = reg_rdata;
    endtask

    // Bounded wait for a request line; always lets one edge land first.
    task automatic wait_irq(input logic rx);
        int n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while ((rx ? rx_irq : tx_irq) !== 1'b1 && n < 3000);
        check(rx ? rx_irq : tx_irq, 1'b1, "request wait");
    endtask

    // Look for two consecutive words seen by the codec model.
    task automatic find_pair(input logic [15:0] a, b, input logic mono);
        logic hit = 1'b0;
        for (int i = 1; i < codec.seen.size(); i++)
            if (codec.seen[i-1][15:0] === a && codec.seen[i][15:0] === b &&
                (!mono || (!codec.seen[i-1][16] && codec.seen[i][16])))
                hit = 1'b1;
        check(hit, 1'b1, "transmitted pair");
    endtask

    // Single exit point of the run.
    task give_verdict;
        $display("Checks %0d, errors %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Main sequence.
    initial begin
        rst = 1'b1;
        reg_addr = 16'h0000;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        gen = 1'b0;
        left_w = 16'h7D7C;
        right_w = 16'h0078;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        wr(16'hDE40, 8'hFF);
        foreach (rst_addr[i]) begin
            rd(rst_addr[i], rv);
            check(rv, 8'h00, "reset value");
        end
        // Standalone codec and plain storage, read right after writing.
        foreach (rows[i]) begin
            // single codec enable; the last row checks priority.
            wr(`ADDR_CONFIG_0, rows[i][47:40]);
            wr(`ADDR_SAMPLE_LOW, rows[i][39:32]);
            wr(`ADDR_SAMPLE_HIGH, rows[i][31:24]);
            rd(`ADDR_SAMPLE_HIGH, rv);
            check(rv, rows[i][23:16], "sample high");
            rd(`ADDR_SAMPLE_LOW, rl);
            if (rows[i][0]) check(rl, rows[i][15:8], "sample low");
            rd(`ADDR_CONFIG_0, rv);
            check(rv, rows[i][47:40], "config");
        end
        // Master, mono with expansion; second write lands on a left slot.
        wr(`ADDR_CONFIG_0, 8'hAB);
        wr(`ADDR_SAMPLE_HIGH, 8'h80);
        wait_irq(1'b0);
        wr(`ADDR_SAMPLE_HIGH, 8'h80);
        wait_irq(1'b0);
        repeat (300) @(posedge sys_clk);
        find_pair(16'h7D7C, 16'h7D7C, 1'b1);
        // Stereo; the low byte is cleared when not rewritten.
        wr(`ADDR_CONFIG_0, 8'h83);
        wr(`ADDR_SAMPLE_LOW, 8'h34);
        wr(`ADDR_SAMPLE_HIGH, 8'h12);
        wait_irq(1'b0);
        wr(`ADDR_SAMPLE_HIGH, 8'hAB);
        wait_irq(1'b0);
        repeat (300) @(posedge sys_clk);
        find_pair(16'h1234, 16'hAB00, 1'b0);
        // Reset in mid-run releases the pins and clears the config.
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        check(sck_oe, 1'b0, "pins in reset");
        rst <= 1'b0;
        @(posedge sys_clk);
        rd(`ADDR_CONFIG_0, rv);
        check(rv, 8'h00, "config after reset");
        // Slave, mono receive with compression; first word is discarded.
        gen <= 1'b1;
        wr(`ADDR_CONFIG_0, 8'h55);
        wait_irq(1'b1);
        rd(`ADDR_SAMPLE_HIGH, rv);
        repeat (3) begin
            wait_irq(1'b1);
            rd(`ADDR_SAMPLE_HIGH, rv);
            check(rv, 8'h80, "mono compressed");
        end
        // Slave stereo receive: words alternate between the channels.
        wr(`ADDR_CONFIG_0, 8'h41);
        wait_irq(1'b1);
        rd(`ADDR_SAMPLE_HIGH, rv);
        prev = 16'h0000;
        repeat (4) begin
            wait_irq(1'b1);
            rd(`ADDR_SAMPLE_LOW, rl);
            rd(`ADDR_SAMPLE_HIGH, rv);
            w = {rv, rl};
            check({w !== prev, w === left_w || w === right_w}, 2'b11,
                "stereo word");
            prev = w;
        end
        // Disabled: the link traffic must raise no receive request.
        wr(`ADDR_CONFIG_0, 8'h40);
        repeat (300) @(posedge sys_clk);
        check(rx_irq, 1'b0, "receive while off");
        gen <= 1'b0;
        give_verdict;
    end

    // Watchdog, well beyond the few thousand cycles the run needs.
    initial begin
        #2000000;
        fail_count++;
        $display("[ERR] %0t watchdog expired", $time);
        give_verdict;
    end
endmodule // tb_audio_serial_config
